/* logic/sbc_pkg.sv */
package sbc_pkg;

  localparam logic [6:0] ADDR_MODE       = 7'h01;
  localparam logic [6:0] ADDR_SYS_EN     = 7'h04;
  localparam logic [6:0] ADDR_SUP_EN     = 7'h1C;
  localparam logic [6:0] ADDR_TRX_EN     = 7'h23;
  localparam logic [6:0] ADDR_WAKE_EN    = 7'h4C;
  localparam logic [6:0] ADDR_GLOBAL     = 7'h60;
  localparam logic [6:0] ADDR_SYS_FLAGS  = 7'h61;
  localparam logic [6:0] ADDR_SUP_FLAGS  = 7'h62;
  localparam logic [6:0] ADDR_TRX_FLAGS  = 7'h63;
  localparam logic [6:0] ADDR_WAKE_FLAGS = 7'h64;

  localparam int SYS_PO         = 4;
  localparam int SYS_OTW        = 2;
  localparam int SYS_SERIAL_FAULT_FLAG       = 1;
  localparam int SYS_WDF        = 0;
  localparam int SUP_VEXT_OVER  = 2;
  localparam int SUP_VEXT_UNDER = 1;
  localparam int SUP_V1_UNDER   = 0;
  localparam int TRX_PN_ERR     = 5;
  localparam int TRX_SILENCE    = 4;
  localparam int TRX_CAN_FAIL   = 1;
  localparam int TRX_CAN_WAKE   = 0;
  localparam int WAKE_RISE      = 1;
  localparam int WAKE_FALL      = 0;
  localparam int GLB_WAKE       = 3;
  localparam int GLB_TRX        = 2;
  localparam int GLB_SUP        = 1;
  localparam int GLB_SYS        = 0;

  localparam logic [7:0] SYS_EN_MASK  = 8'h06;
  localparam logic [7:0] SUP_EN_MASK  = 8'h07;
  localparam logic [7:0] TRX_EN_MASK  = 8'h13;
  localparam logic [7:0] WAKE_EN_MASK = 8'h03;
  localparam logic [7:0] EN_RESET     = 8'h00;

  localparam logic [2:0] MC_SLEEP   = 3'h1;
  localparam logic [2:0] MC_STANDBY = 3'h4;
  localparam logic [2:0] MC_NORMAL  = 3'h7;

  localparam int         SPI_FRAME_BITS = 16;
  localparam int         SPI_HDR_BITS   = 8;
  localparam logic [5:0] SPI_CNT_MAX    = 6'h3F;

  localparam int         CLK_PERIOD_NS = 25;
  localparam int         EVT_DELAY_NS  = 1000;
  localparam int         EVT_DELAY_CNT = (EVT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         RST_HOLD_NS   = 1000;
  localparam int         RST_HOLD_CNT  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         TMR_W         = 12;
  localparam logic [11:0] EVT_DELAY_CYC = 12'(EVT_DELAY_CNT);
  localparam logic [11:0] RST_HOLD_LAST = 12'(RST_HOLD_CNT - 1);

  typedef enum logic [2:0] {
    ST_OFF, ST_RESET, ST_STANDBY, ST_NORMAL, ST_SLEEP, ST_OVERTEMP
  } sbc_state_e;

endpackage : sbc_pkg

/* logic/sbc_flag_bank.sv */
module sbc_flag_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] set_ev,
  input  wire logic             clr_wr,
  input  wire logic [WIDTH-1:0] clr_mask,
  output logic      [WIDTH-1:0] flags,
  output logic                  cleared
);
  import sbc_pkg::*;

  logic [WIDTH-1:0] clr_hit;

  assign clr_hit = clr_wr ? (flags & clr_mask) : '0;
  assign cleared = |clr_hit;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~clr_hit) | set_ev;
    end
  end

endmodule : sbc_flag_bank

/* logic/sbc_spi_frame.sv */
module sbc_spi_frame (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       spi_sck,
  input  wire logic       spi_cs_b,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  input  wire logic [7:0] rd_data,
  output logic      [6:0] frm_addr,
  output logic            frm_fetch,
  output logic            frm_wr,
  output logic      [7:0] frm_wdata,
  output logic            frm_len_err
);
  import sbc_pkg::*;

  logic        sck_prev;
  logic        cs_prev_b;
  logic [5:0]  bit_cnt;
  logic [15:0] shift_in;
  logic [7:0]  shift_out;
  logic        read_only;
  logic        sck_rise;
  logic        sck_fall;
  logic        frm_start;
  logic        frm_end;

  assign sck_rise  = !spi_cs_b && spi_sck && !sck_prev;
  assign sck_fall  = !spi_cs_b && !spi_sck && sck_prev;
  assign frm_start = cs_prev_b && !spi_cs_b;
  assign frm_end   = !cs_prev_b && spi_cs_b;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sck_prev  <= 1'b0;
      cs_prev_b <= 1'b1;
    end else begin
      sck_prev  <= spi_sck;
      cs_prev_b <= spi_cs_b;
    end
  end

  // mosi sampled on falling sck, header is seven address bits then read-only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt   <= 6'h00;
      shift_in  <= 16'h0000;
      frm_addr  <= 7'h00;
      read_only <= 1'b0;
      frm_fetch <= 1'b0;
    end else begin
      frm_fetch <= 1'b0;
      if (frm_start) begin
        bit_cnt <= 6'h00;
      end else if (sck_fall) begin
        shift_in <= {shift_in[14:0], spi_mosi};
        if (bit_cnt != SPI_CNT_MAX) begin
          bit_cnt <= bit_cnt + 6'h01;
        end
        if (bit_cnt == 6'(SPI_HDR_BITS - 1)) begin
          frm_addr  <= shift_in[6:0];
          read_only <= spi_mosi;
          frm_fetch <= 1'b1;
        end
      end
    end
  end

  // read data is loaded one cycle after the header completes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_out <= 8'h00;
      spi_miso  <= 1'b0;
    end else if (frm_fetch) begin
      shift_out <= rd_data;
    end else if (sck_rise && bit_cnt >= 6'(SPI_HDR_BITS)) begin
      spi_miso  <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end else if (frm_start) begin
      spi_miso <= 1'b0;
    end
  end

  // only whole 16-bit frames write; anything else is a length fault
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frm_wr      <= 1'b0;
      frm_wdata   <= 8'h00;
      frm_len_err <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= !spi_cs_b;
      frm_wr      <= frm_end && bit_cnt == 6'(SPI_FRAME_BITS) && !read_only;
      frm_len_err <= frm_end && bit_cnt != 6'(SPI_FRAME_BITS);
      if (frm_end) begin
        frm_wdata <= shift_in[7:0];
      end
    end
  end

endmodule : sbc_spi_frame

/* logic/sbc_evt_core.sv */
module sbc_evt_core (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_b,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  input  wire logic        ev_watchdog_fail,
  input  wire logic        ev_overtemp_warn,
  input  wire logic        ev_vext_over,
  input  wire logic        ev_vext_under,
  input  wire logic        ev_v1_under,
  input  wire logic        ev_pn_frame_err,
  input  wire logic        ev_bus_silence,
  input  wire logic        ev_can_fail,
  input  wire logic        ev_can_wake,
  input  wire logic        wake_pin,
  input  wire logic        trx_offline,
  input  wire logic        ot_shutdown,
  input  wire logic        sleep_lock_bit,
  output logic             evt_rxd_low,
  output logic             mcu_supply,
  output logic             reset_out_low,
  output sbc_pkg::sbc_state_e op_state
);
  import sbc_pkg::*;

  localparam int RST_BOUND = RST_HOLD_CNT + 2;

  logic             rst_meta_b;
  logic             rst_sync_b;
  logic [6:0]       frm_addr;
  logic             frm_fetch;
  logic             frm_wr;
  logic [7:0]       frm_wdata;
  logic             frm_len_err;
  logic [7:0]       rd_data;
  logic [7:0]       sys_en;
  logic [7:0]       sup_en;
  logic [7:0]       trx_en;
  logic [7:0]       wake_en;
  logic [2:0]       cmd_code;
  logic [7:0]       sys_set;
  logic [7:0]       sup_set;
  logic [7:0]       trx_set;
  logic [7:0]       wake_set;
  logic [7:0]       sys_flags;
  logic [7:0]       sup_flags;
  logic [7:0]       trx_flags;
  logic [7:0]       wake_flags;
  logic             sys_clr;
  logic             sup_clr;
  logic             trx_clr;
  logic             wake_clr;
  logic             any_cleared;
  logic             pending_any;
  logic [7:0]       global_sum;
  logic             wake_prev;
  logic             wake_armed;
  logic             wake_rise;
  logic             wake_fall;
  logic             po_pulse;
  logic             mode_wr;
  logic             mode_legal;
  logic             sleep_req;
  logic             lock_fault;
  logic             serial_fault_flag_ev;
  logic             regular_enabled;
  sbc_state_e       state;
  sbc_state_e       next_state;
  logic [TMR_W-1:0] rst_cnt;
  logic [TMR_W-1:0] tmr;
  logic             tmr_idle;
  logic             next_rstout_low;
  logic             rstout_fall;
  logic             offline_window;
  logic             next_rxd_low;

  // release of the async reset is synchronised, assertion stays async
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  sbc_spi_frame u_spi (
    .mclk        (mclk),
    .rst_b       (rst_sync_b),
    .spi_sck     (spi_sck),
    .spi_cs_b    (spi_cs_b),
    .spi_mosi    (spi_mosi),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe),
    .rd_data     (rd_data),
    .frm_addr    (frm_addr),
    .frm_fetch   (frm_fetch),
    .frm_wr      (frm_wr),
    .frm_wdata   (frm_wdata),
    .frm_len_err (frm_len_err)
  );

  // capture enables, all disabled after power-on
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sys_en  <= EN_RESET;
      sup_en  <= EN_RESET;
      trx_en  <= EN_RESET;
      wake_en <= EN_RESET;
    end else if (frm_wr) begin
      if (frm_addr == ADDR_SYS_EN) begin
        sys_en <= frm_wdata & SYS_EN_MASK;
      end
      if (frm_addr == ADDR_SUP_EN) begin
        sup_en <= frm_wdata & SUP_EN_MASK;
      end
      if (frm_addr == ADDR_TRX_EN) begin
        trx_en <= frm_wdata & TRX_EN_MASK;
      end
      if (frm_addr == ADDR_WAKE_EN) begin
        wake_en <= frm_wdata & WAKE_EN_MASK;
      end
    end
  end

  // armed flag stops a high pin at reset release looking like an edge
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wake_prev  <= 1'b0;
      wake_armed <= 1'b0;
    end else begin
      wake_prev  <= wake_pin;
      wake_armed <= 1'b1;
    end
  end

  assign wake_rise = wake_armed && wake_pin && !wake_prev;
  assign wake_fall = wake_armed && !wake_pin && wake_prev;

  assign po_pulse   = (state == ST_OFF);
  assign mode_wr    = frm_wr && (frm_addr == ADDR_MODE);
  assign mode_legal = (frm_wdata[2:0] == MC_SLEEP) || (frm_wdata[2:0] == MC_STANDBY) ||
                      (frm_wdata[2:0] == MC_NORMAL);
  assign sleep_req  = mode_wr && (frm_wdata[2:0] == MC_SLEEP) &&
                      (state == ST_STANDBY || state == ST_NORMAL);
  assign lock_fault = sleep_req && sleep_lock_bit;
  assign serial_fault_flag_ev    = frm_len_err || lock_fault || (mode_wr && !mode_legal);

  assign regular_enabled = trx_en[TRX_CAN_WAKE] || wake_en[WAKE_RISE] || wake_en[WAKE_FALL];

  always_comb begin
    sys_set  = 8'h00;
    sup_set  = 8'h00;
    trx_set  = 8'h00;
    wake_set = 8'h00;
    sys_set[SYS_PO]    = po_pulse;
    sys_set[SYS_WDF]   = ev_watchdog_fail;
    trx_set[TRX_PN_ERR] = ev_pn_frame_err;
    sys_set[SYS_OTW]          = ev_overtemp_warn && sys_en[SYS_OTW];
    sys_set[SYS_SERIAL_FAULT_FLAG]         = serial_fault_flag_ev && sys_en[SYS_SERIAL_FAULT_FLAG];
    sup_set[SUP_VEXT_OVER]    = ev_vext_over && sup_en[SUP_VEXT_OVER];
    sup_set[SUP_VEXT_UNDER]   = ev_vext_under && sup_en[SUP_VEXT_UNDER];
    sup_set[SUP_V1_UNDER]     = ev_v1_under && sup_en[SUP_V1_UNDER];
    trx_set[TRX_SILENCE]      = ev_bus_silence && trx_en[TRX_SILENCE];
    trx_set[TRX_CAN_FAIL]     = ev_can_fail && trx_en[TRX_CAN_FAIL];
    trx_set[TRX_CAN_WAKE]     = ev_can_wake && trx_en[TRX_CAN_WAKE];
    wake_set[WAKE_RISE]       = wake_rise && wake_en[WAKE_RISE];
    wake_set[WAKE_FALL]       = wake_fall && wake_en[WAKE_FALL];
  end

  sbc_flag_bank #(.WIDTH(8)) u_sys (
    .mclk     (mclk),
    .rst_b    (rst_sync_b),
    .set_ev   (sys_set),
    .clr_wr   (frm_wr && frm_addr == ADDR_SYS_FLAGS),
    .clr_mask (frm_wdata),
    .flags    (sys_flags),
    .cleared  (sys_clr)
  );

  sbc_flag_bank #(.WIDTH(8)) u_sup (
    .mclk     (mclk),
    .rst_b    (rst_sync_b),
    .set_ev   (sup_set),
    .clr_wr   (frm_wr && frm_addr == ADDR_SUP_FLAGS),
    .clr_mask (frm_wdata),
    .flags    (sup_flags),
    .cleared  (sup_clr)
  );

  sbc_flag_bank #(.WIDTH(8)) u_trx (
    .mclk     (mclk),
    .rst_b    (rst_sync_b),
    .set_ev   (trx_set),
    .clr_wr   (frm_wr && frm_addr == ADDR_TRX_FLAGS),
    .clr_mask (frm_wdata),
    .flags    (trx_flags),
    .cleared  (trx_clr)
  );

  sbc_flag_bank #(.WIDTH(8)) u_wake (
    .mclk     (mclk),
    .rst_b    (rst_sync_b),
    .set_ev   (wake_set),
    .clr_wr   (frm_wr && frm_addr == ADDR_WAKE_FLAGS),
    .clr_mask (frm_wdata),
    .flags    (wake_flags),
    .cleared  (wake_clr)
  );

  assign any_cleared = sys_clr || sup_clr || trx_clr || wake_clr;
  assign pending_any = |{sys_flags, sup_flags, trx_flags, wake_flags};

  assign global_sum = {4'h0, |wake_flags, |trx_flags, |sup_flags, |sys_flags};

  always_comb begin
    case (frm_addr)
      ADDR_MODE:       rd_data = {5'h00, cmd_code};
      ADDR_SYS_EN:     rd_data = sys_en;
      ADDR_SUP_EN:     rd_data = sup_en;
      ADDR_TRX_EN:     rd_data = trx_en;
      ADDR_WAKE_EN:    rd_data = wake_en;
      ADDR_GLOBAL:     rd_data = global_sum;
      ADDR_SYS_FLAGS:  rd_data = sys_flags;
      ADDR_SUP_FLAGS:  rd_data = sup_flags;
      ADDR_TRX_FLAGS:  rd_data = trx_flags;
      ADDR_WAKE_FLAGS: rd_data = wake_flags;
      default:         rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cmd_code <= MC_STANDBY;
    end else if (mode_wr && mode_legal && !lock_fault) begin
      cmd_code <= frm_wdata[2:0];
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_OFF: begin
        next_state = ST_RESET;
      end
      ST_RESET: begin
        if (rst_cnt == RST_HOLD_LAST) begin
          next_state = ST_STANDBY;
        end
      end
      ST_STANDBY, ST_NORMAL: begin
        if (sleep_req) begin
          if (lock_fault) begin
            next_state = state;
          end else if (!regular_enabled) begin
            next_state = ST_RESET;
          end else if (pending_any) begin
            next_state = ST_RESET;
          end else begin
            next_state = ST_SLEEP;
          end
        end else if (mode_wr && frm_wdata[2:0] == MC_STANDBY) begin
          next_state = ST_STANDBY;
        end else if (mode_wr && frm_wdata[2:0] == MC_NORMAL) begin
          next_state = ST_NORMAL;
        end
      end
      ST_SLEEP: begin
        if (pending_any) begin
          next_state = ST_RESET;
        end
      end
      ST_OVERTEMP: begin
        if (!ot_shutdown) begin
          next_state = ST_RESET;
        end
      end
    endcase
    if (ot_shutdown && state != ST_OFF) begin
      next_state = ST_OVERTEMP;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rst_cnt <= '0;
    end else if (state == ST_RESET) begin
      rst_cnt <= rst_cnt + 12'h001;
    end else begin
      rst_cnt <= '0;
    end
  end

  assign next_rstout_low = !(next_state == ST_RESET || next_state == ST_SLEEP ||
                             next_state == ST_OVERTEMP || next_state == ST_OFF);

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reset_out_low <= 1'b0;
      mcu_supply    <= 1'b0;
      op_state      <= ST_OFF;
    end else begin
      reset_out_low <= next_rstout_low;
      mcu_supply    <= !(next_state == ST_SLEEP || next_state == ST_OFF ||
                         next_state == ST_OVERTEMP);
      op_state      <= next_state;
    end
  end

  // timer clears on the same edge the reset output falls
  assign rstout_fall = reset_out_low && !next_rstout_low;
  assign tmr_idle    = (tmr == '0);

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tmr <= '0;
    end else if (rstout_fall) begin
      tmr <= '0;
    end else if (any_cleared) begin
      tmr <= EVT_DELAY_CYC;
    end else if (!tmr_idle) begin
      tmr <= tmr - 12'h001;
    end
  end

  assign offline_window = trx_offline && mcu_supply &&
                          (state == ST_NORMAL || state == ST_STANDBY);

  // pending after expiry, high when none, sleep signals
  assign next_rxd_low = pending_any && tmr_idle && !any_cleared &&
                        (offline_window || state == ST_SLEEP);

  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      evt_rxd_low <= 1'b0;
    end else begin
      evt_rxd_low <= next_rxd_low;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_sync_b);

  sequence s_clear_wdf;
    frm_wr && frm_addr == ADDR_SYS_FLAGS && frm_wdata[SYS_WDF];
  endsequence

  sequence s_expire;
    tmr == 12'h001 && !any_cleared && !rstout_fall;
  endsequence

  a_core_capture: assert property (ev_pn_frame_err |=> trx_flags[TRX_PN_ERR])
    else $error("pn frame error not latched");
  a_gated_capture: assert property ($rose(trx_flags[TRX_CAN_WAKE]) |->
    $past(trx_en[TRX_CAN_WAKE] && ev_can_wake))
    else $error("can wake latched while disabled");
  a_rxd_indicate: assert property (pending_any && tmr_idle && !any_cleared &&
    offline_window |=> evt_rxd_low)
    else $error("pending event not shown on rxd");
  a_sleep_wake: assert property (state == ST_SLEEP && pending_any && !ot_shutdown
    |=> state == ST_RESET && mcu_supply ##[1:RST_BOUND] state == ST_STANDBY)
    else $error("sleep wake did not pass reset to standby");
  a_group_summary: assert property (frm_fetch && frm_addr == ADDR_GLOBAL |->
    rd_data[7:4] == 4'h0 && rd_data[GLB_TRX] == |trx_flags && rd_data[GLB_SYS] == |sys_flags)
    else $error("summary read wrong");
  a_w1c_clear: assert property (s_clear_wdf ##0 !ev_watchdog_fail |=> !sys_flags[SYS_WDF])
    else $error("write one did not clear");
  a_set_wins: assert property (s_clear_wdf ##0 ev_watchdog_fail |=> sys_flags[SYS_WDF])
    else $error("event lost against clear");
  a_clear_release: assert property (any_cleared |=> !evt_rxd_low && tmr == EVT_DELAY_CYC)
    else $error("clear did not release rxd and start timer");
  a_expiry_signal: assert property (s_expire ##1 (pending_any && offline_window &&
    !any_cleared) |=> evt_rxd_low)
    else $error("pending not signalled after delay");
  a_expiry_quiet: assert property (s_expire ##1 !pending_any |=> !evt_rxd_low)
    else $error("rxd low with nothing pending");
  a_timer_stop: assert property ($fell(reset_out_low) |-> tmr_idle)
    else $error("timer kept running after reset fall");
  a_reset_low: assert property (state inside {ST_RESET, ST_SLEEP, ST_OVERTEMP, ST_OFF}
    |-> !reset_out_low)
    else $error("reset output high in reset-class state");
  a_no_wake_reset: assert property (sleep_req && !sleep_lock_bit && !regular_enabled
    && !ot_shutdown |=> state == ST_RESET)
    else $error("sleep without wake source not reset");
  a_pending_reset: assert property (sleep_req && !sleep_lock_bit && pending_any
    && !ot_shutdown |=> state == ST_RESET)
    else $error("sleep with pending flag not reset");
  a_sleep_lock: assert property (sleep_req && sleep_lock_bit && sys_en[SYS_SERIAL_FAULT_FLAG]
    |=> sys_flags[SYS_SERIAL_FAULT_FLAG] && state != ST_SLEEP)
    else $error("locked sleep not refused");
  a_wake_rise: assert property (wake_rise && wake_en[WAKE_RISE] |=> wake_flags[WAKE_RISE])
    else $error("wake rise not latched");

endmodule : sbc_evt_core

/* test/sbc_host_model.sv */
module sbc_host_model (
  input  wire logic mclk,
  input  wire logic spi_miso,
  input  wire logic spi_miso_oe,
  output logic      spi_sck,
  output logic      spi_cs_b,
  output logic      spi_mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_sck = 1'b0;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic xfer(input logic [6:0] a, input logic ro, input logic [7:0] d,
                      output logic [7:0] q);
    logic [15:0] f;
    f = {a, ro, d};
    @(negedge mclk) spi_cs_b = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = f[i];
      repeat (2) @(negedge mclk);
      spi_sck = 1'b1;
      repeat (2) @(negedge mclk);
      // undriven miso reads as pulled high
      q = {q[6:0], spi_miso_oe ? spi_miso : 1'b1};
      spi_sck = 1'b0;
      // mosi must still stand when the falling sck is seen
      @(negedge mclk);
    end
    repeat (2) @(negedge mclk);
    spi_cs_b = 1'b1;
    spi_mosi = ~spi_mosi;
    repeat (3) @(negedge mclk);
  endtask : xfer
endmodule : sbc_host_model

/* test/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sbc_pkg::*;
  logic mclk, rst_b, sck, cs_b, mosi, miso, oe, wake, rxd, sup, rsto, lock, off;
  logic [9:0] ev;
  logic [7:0] q;
  sbc_state_e st;
  int num_errors = 0;
  int comparisons = 0;
  sbc_host_model hst_i (.mclk(mclk), .spi_miso(miso), .spi_miso_oe(oe), .spi_sck(sck),
    .spi_cs_b(cs_b), .spi_mosi(mosi));
  sbc_evt_core sbc_evt_core_i (.mclk(mclk), .rst_b(rst_b), .spi_sck(sck), .spi_cs_b(cs_b),
    .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe), .ev_watchdog_fail(ev[0]),
    .ev_overtemp_warn(ev[1]), .ev_vext_over(ev[2]), .ev_vext_under(ev[3]),
    .ev_v1_under(ev[4]), .ev_pn_frame_err(ev[5]), .ev_bus_silence(ev[6]),
    .ev_can_fail(ev[7]), .ev_can_wake(ev[8]), .wake_pin(wake), .trx_offline(off),
    .ot_shutdown(ev[9]), .sleep_lock_bit(lock), .evt_rxd_low(rxd), .mcu_supply(sup),
    .reset_out_low(rsto), .op_state(st));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    hst_i.xfer(a, 1'b1, 8'h00, q);
    chk("register", q, e);
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    hst_i.xfer(a, 1'b0, d, q);
  endtask : wr
  task automatic pulse(input int i);
    @(negedge mclk) ev[i] = 1'b1;
    @(negedge mclk) ev[i] = 1'b0;
  endtask : pulse
  task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    ev = '0;
    wake = 1'b0;
    lock = 1'b0;
    off = 1'b1;
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    repeat (60) @(negedge mclk);
    chk("rxd", 8'(rxd), 8'h01);
    rd(ADDR_SYS_FLAGS, 8'h10);
    rd(ADDR_GLOBAL, 8'h01);
    wr(ADDR_SYS_FLAGS, 8'h10);
    chk("rxd", 8'(rxd), 8'h00);
    pulse(0);
    chk("rxd", 8'(rxd), 8'h00);
    repeat (40) @(negedge mclk);
    chk("rxd", 8'(rxd), 8'h01);
    pulse(1);
    rd(ADDR_SYS_FLAGS, 8'h01);
    wr(ADDR_SYS_EN, 8'h04);
    pulse(1);
    rd(ADDR_SYS_FLAGS, 8'h05);
    wr(ADDR_SYS_FLAGS, 8'h05);
    repeat (50) @(negedge mclk);
    chk("rxd", 8'(rxd), 8'h00);
    rd(ADDR_SYS_FLAGS, 8'h00);
    wr(ADDR_WAKE_EN, 8'h02);
    @(negedge mclk) wake = 1'b1;
    repeat (4) @(negedge mclk) wake = 1'b0;
    repeat (4) @(negedge mclk);
    rd(ADDR_WAKE_FLAGS, 8'h02);
    rd(ADDR_GLOBAL, 8'h08);
    wr(ADDR_MODE, 8'h01);
    chk("state", 8'(st), 8'(ST_RESET));
    chk("rst out", 8'(rsto), 8'h00);
    repeat (50) @(negedge mclk);
    chk("state", 8'(st), 8'(ST_STANDBY));
    // clear only what was seen set
    hst_i.xfer(ADDR_WAKE_FLAGS, 1'b1, 8'h00, q);
    wr(ADDR_WAKE_FLAGS, q);
    hst_i.xfer(ADDR_SYS_FLAGS, 1'b1, 8'h00, q);
    wr(ADDR_SYS_FLAGS, q);
    wr(ADDR_WAKE_EN, 8'h00);
    wr(ADDR_MODE, 8'h01);
    chk("state", 8'(st), 8'(ST_RESET));
    repeat (50) @(negedge mclk);
    wr(ADDR_TRX_EN, 8'h01);
    wr(ADDR_MODE, 8'h01);
    chk("state", 8'(st), 8'(ST_SLEEP));
    chk("supply", 8'(sup), 8'h00);
    chk("rst out", 8'(rsto), 8'h00);
    pulse(8);
    repeat (50) @(negedge mclk);
    chk("state", 8'(st), 8'(ST_STANDBY));
    chk("supply", 8'(sup), 8'h01);
    rd(ADDR_TRX_FLAGS, 8'h01);
    pulse(5);
    rd(ADDR_TRX_FLAGS, 8'h21);
    wr(ADDR_SYS_EN, 8'h06);
    @(negedge mclk) lock = 1'b1;
    wr(ADDR_MODE, 8'h01);
    chk("state", 8'(st), 8'(ST_STANDBY));
    rd(ADDR_SYS_FLAGS, 8'h02);
    wr(ADDR_MODE, 8'h07);
    chk("state", 8'(st), 8'(ST_NORMAL));
    chk("rxd", 8'(rxd), 8'h01);
    @(negedge mclk) off = 1'b0;
    repeat (2) @(negedge mclk);
    chk("rxd", 8'(rxd), 8'h00);
    test_done();
  end
endmodule : tb_top
